// File: inc/pcc_pkg.sv
// Constants and carrier types for the loop compensator and telemetry core.
// Assumes a single 50 MHz clock and an external switching-period tick.
package pcc_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int MON_RATE_HZ = 700;
    localparam int MON_CH = 3;
    localparam int SLOT_CYC = CLK_HZ / (MON_RATE_HZ * MON_CH);
    localparam logic [3:0] COEF_LAST_ADDR = 4'ha;
    localparam logic [3:0] COEF_DEN_BASE = 4'h8;
    localparam logic [2:0] COEF_DEN_OFS = 3'h4;
    localparam logic [2:0] MAC_LAST = 3'h7;
    localparam int FRAC_BITS = 12;
    localparam int DEN_FRAC = 6;
    localparam logic [15:0] DUTY_MAX = 16'h0fff;
    localparam logic [15:0] RESULT_MAX = 16'h00ff;
    localparam logic [15:0] TRIM_MAX = 16'h00ff;
    localparam logic [8:0] TEMP_REF = 9'h019;
    localparam int TEMP_SHIFT = 8;
    localparam logic [15:0] SHARE_BIT_CYC = 16'h0032;
    localparam logic [2:0] SHARE_LAST_BIT = 3'h7;
    localparam logic [1:0] CH_VOUT = 2'h0;
    localparam logic [1:0] CH_IOUT = 2'h1;
    localparam logic [1:0] CH_TEMP = 2'h2;
    localparam logic [15:0] COEF_RST = 16'h0000;

    typedef struct packed {
        logic [7:0] vout;
        logic [7:0] iout;
        logic [7:0] temp;
    } pcc_mon_s;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] data;
    } pcc_coef_wr_s;

    typedef enum logic [1:0] {ST_IDLE, ST_MAC, ST_DONE} pcc_state_e;
endpackage : pcc_pkg

// File: src/pcc_coef_mem.sv
// Coefficient store: seven 16-bit words with byte-lane writes.
// Assumes the caller decodes coefficient addresses into word and lanes.
`timescale 1ns/100ps
module pcc_coef_mem
    import pcc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic wr_en_in,
    input wire logic [2:0] wr_word_in,
    input wire logic wr_hi_in,
    input wire logic wr_lo_in,
    input wire logic [7:0] wr_data_in,
    input wire logic [2:0] rd_addr_in,
    output logic [15:0] rd_data_out
);
    logic [15:0] mem_reg [0:6];

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < 7; i++) begin
                mem_reg[i] <= COEF_RST;
            end
        end else if (wr_en_in) begin
            if (wr_hi_in) begin
                mem_reg[wr_word_in][15:8] <= wr_data_in;
            end
            if (wr_lo_in) begin
                mem_reg[wr_word_in][7:0] <= wr_data_in;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_out <= COEF_RST;
        end else begin
            rd_data_out <= mem_reg[rd_addr_in];
        end
    end

    coef_high_a: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_en_in && wr_hi_in |=> mem_reg[$past(wr_word_in)][15:8]
            == $past(wr_data_in))
        else $error("Coefficient high byte not stored.");
endmodule : pcc_coef_mem

// File: src/pcc_core.sv
// Loop compensator, current share link and telemetry for a POL converter.
// Assumes err_in is valid at sw_tick_in and the ADC answers each start.
`timescale 1ns/100ps
module pcc_core
    import pcc_pkg::*;
#(
    parameter int SLOT_CYCLES = SLOT_CYC
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic sw_tick_in,
    input wire logic signed [7:0] err_in,
    input wire logic coef_wr_in,
    input wire pcc_coef_wr_s coef_in,
    input wire logic [7:0] adc_data_in,
    input wire logic adc_valid_in,
    input wire logic retrieve_en_in,
    input wire logic share_sync_in,
    input wire logic cs_in,
    output logic [11:0] duty_out,
    output logic duty_valid_out,
    output logic adc_start_out,
    output logic [1:0] adc_ch_out,
    output pcc_mon_s mon_out,
    output logic mon_tx_valid_out,
    output pcc_mon_s mon_tx_data_out,
    output logic cs_out,
    output logic cs_oe_n_out
);
    function automatic logic [15:0] clamp(input logic signed [39:0] v,
                                          input logic [15:0] lim);
        if (v < 0) begin
            return 16'h0000;
        end
        if (v > $signed({24'h000000, lim})) begin
            return lim;
        end
        return v[15:0];
    endfunction : clamp

    pcc_state_e state_reg;
    logic [2:0] idx_reg;
    logic signed [39:0] acc_reg;
    logic signed [15:0] hist_reg [0:6];
    logic [15:0] coef_word;
    logic [2:0] wr_word;
    logic den_sel;
    logic signed [39:0] term;
    logic signed [39:0] y_sum;
    logic [15:0] y_next;
    logic [7:0] trim_reg;

    // Numerator codes 0..7 pair high/low; codes 8..10 are denominators.
    assign den_sel = coef_in.addr >= COEF_DEN_BASE;
    assign wr_word = den_sel ? coef_in.addr[2:0] + COEF_DEN_OFS
                             : coef_in.addr[3:1];

    pcc_coef_mem u_mem (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .wr_en_in(coef_wr_in && coef_in.addr <= COEF_LAST_ADDR),
        .wr_word_in(wr_word),
        .wr_hi_in(!den_sel && !coef_in.addr[0]),
        .wr_lo_in(den_sel || coef_in.addr[0]),
        .wr_data_in(coef_in.data),
        .rd_addr_in(idx_reg),
        .rd_data_out(coef_word)
    );

    // Word k-1 arrives while idx is k; numerators weight past errors,
    // denominators weight past outputs with the opposite sign.
    always_comb begin
        term = '0;
        if (idx_reg <= 3'h4) begin
            term = 40'($signed(coef_word) * hist_reg[idx_reg - 3'h1]);
        end else begin
            term = -(40'($signed(coef_word[7:0]) * hist_reg[idx_reg - 3'h1])
                     <<< (FRAC_BITS - DEN_FRAC));
        end
    end

    assign y_sum = (acc_reg >>> FRAC_BITS) + $signed({32'h0, trim_reg});
    assign y_next = clamp(y_sum, DUTY_MAX);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= ST_IDLE;
            idx_reg <= 3'h0;
            acc_reg <= '0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (sw_tick_in) begin
                        state_reg <= ST_MAC;
                        idx_reg <= 3'h0;
                        acc_reg <= '0;
                    end
                end
                ST_MAC: begin
                    if (idx_reg != 3'h0) begin
                        acc_reg <= acc_reg + term;
                    end
                    if (idx_reg == MAC_LAST) begin
                        state_reg <= ST_DONE;
                    end else begin
                        idx_reg <= idx_reg + 3'h1;
                    end
                end
                ST_DONE: begin
                    state_reg <= ST_IDLE;
                    idx_reg <= 3'h0;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Past outputs are kept clamped, so the integrator cannot wind up.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < 7; i++) begin
                hist_reg[i] <= 16'sh0000;
            end
        end else if (state_reg == ST_IDLE && sw_tick_in) begin
            hist_reg[0] <= 16'(err_in);
            for (int i = 1; i < 4; i++) begin
                hist_reg[i] <= hist_reg[i - 1];
            end
        end else if (state_reg == ST_DONE) begin
            hist_reg[4] <= $signed(y_next);
            hist_reg[5] <= hist_reg[4];
            hist_reg[6] <= hist_reg[5];
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            duty_out <= 12'h000;
            duty_valid_out <= 1'b0;
        end else begin
            duty_valid_out <= state_reg == ST_DONE;
            if (state_reg == ST_DONE) begin
                duty_out <= y_next[11:0];
            end
        end
    end

    // Wired-AND arbitration: a one bit pulls the line low, so the line
    // carries the largest current of all units sharing it.
    logic share_act_reg;
    logic share_lead_reg;
    logic [2:0] share_bit_reg;
    logic [15:0] share_cnt_reg;
    logic [7:0] share_own_reg;
    logic [7:0] share_max_reg;
    logic own_bit;

    assign own_bit = share_own_reg[3'h7 - share_bit_reg];

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            share_act_reg <= 1'b0;
            share_lead_reg <= 1'b0;
            share_bit_reg <= 3'h0;
            share_cnt_reg <= 16'h0000;
            share_own_reg <= 8'h00;
            share_max_reg <= 8'h00;
            trim_reg <= 8'h00;
            cs_out <= 1'b0;
            cs_oe_n_out <= 1'b1;
        end else if (!share_act_reg) begin
            cs_oe_n_out <= 1'b1;
            if (share_sync_in) begin
                share_act_reg <= 1'b1;
                share_lead_reg <= 1'b1;
                share_bit_reg <= 3'h0;
                share_cnt_reg <= 16'h0000;
                share_own_reg <= mon_out.iout;
            end
        end else begin
            cs_oe_n_out <= !(share_lead_reg && own_bit);
            if (share_cnt_reg == SHARE_BIT_CYC - 16'h0001) begin
                share_cnt_reg <= 16'h0000;
                share_max_reg <= {share_max_reg[6:0], !cs_in};
                if (!own_bit && !cs_in) begin
                    share_lead_reg <= 1'b0;
                end
                if (share_bit_reg == SHARE_LAST_BIT) begin
                    share_act_reg <= 1'b0;
                    cs_oe_n_out <= 1'b1;
                    if (share_own_reg < {share_max_reg[6:0], !cs_in}) begin
                        trim_reg <= 8'(clamp(40'(trim_reg) + 40'sh1,
                                             TRIM_MAX));
                    end else if (trim_reg != 8'h00) begin
                        trim_reg <= trim_reg - 8'h01;
                    end
                end else begin
                    share_bit_reg <= share_bit_reg + 3'h1;
                end
            end else begin
                share_cnt_reg <= share_cnt_reg + 16'h0001;
            end
        end
    end

    // Round-robin conversions: one start per slot, three slots per round.
    logic [31:0] slot_cnt_reg;
    logic signed [8:0] temp_diff;
    logic signed [39:0] i_comp;

    assign temp_diff = $signed({1'b0, mon_out.temp}) - $signed(TEMP_REF);
    assign i_comp = 40'($signed({1'b0, adc_data_in}))
        + ((40'($signed({1'b0, adc_data_in})) * 40'(temp_diff))
           >>> TEMP_SHIFT);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            slot_cnt_reg <= 32'h0;
            adc_start_out <= 1'b0;
            adc_ch_out <= CH_VOUT;
        end else begin
            adc_start_out <= 1'b0;
            if (slot_cnt_reg == 32'(SLOT_CYCLES - 1)) begin
                slot_cnt_reg <= 32'h0;
                adc_start_out <= 1'b1;
                adc_ch_out <= (adc_ch_out == CH_TEMP) ? CH_VOUT
                                                      : adc_ch_out + 2'h1;
            end else begin
                slot_cnt_reg <= slot_cnt_reg + 32'h1;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            mon_out <= '0;
            mon_tx_valid_out <= 1'b0;
            mon_tx_data_out <= '0;
        end else begin
            mon_tx_valid_out <= 1'b0;
            if (adc_valid_in) begin
                case (adc_ch_out)
                    CH_VOUT: mon_out.vout <= adc_data_in;
                    CH_IOUT: mon_out.iout <= 8'(clamp(i_comp, RESULT_MAX));
                    CH_TEMP: begin
                        mon_out.temp <= adc_data_in;
                        mon_tx_valid_out <= retrieve_en_in;
                        mon_tx_data_out <= '{mon_out.vout, mon_out.iout,
                                             adc_data_in};
                    end
                    default: mon_out <= mon_out;
                endcase
            end
        end
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    logic [31:0] gap_reg;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            gap_reg <= 32'h0;
        end else begin
            // Counts cycles since the last start, the cycle after the start being one.
            gap_reg <= adc_start_out ? 32'h1 : gap_reg + 32'h1;
        end
    end

    duty_per_tick_a: assert property (
        state_reg == ST_IDLE && sw_tick_in |-> ##10 duty_valid_out)
        else $error("No duty value after switching tick.");
    mac_length_a: assert property (
        state_reg == ST_MAC && idx_reg == 3'h0 |-> ##7 idx_reg == MAC_LAST
            ##1 state_reg == ST_DONE)
        else $error("Filter sequence has wrong length.");
    output_feedback_a: assert property (
        duty_valid_out |-> hist_reg[4] == $signed({4'h0, duty_out}))
        else $error("Output history not updated.");
    duty_hold_a: assert property (
        !duty_valid_out |-> $stable(duty_out))
        else $error("Duty value changed without a new result.");
    adc_rate_a: assert property (
        gap_reg <= 32'(SLOT_CYCLES))
        else $error("Conversion slot too long.");
    iout_comp_a: assert property (
        adc_valid_in && adc_ch_out == CH_IOUT
            && {1'b0, mon_out.temp} == TEMP_REF
        |=> mon_out.iout == $past(adc_data_in))
        else $error("Current correction wrong at reference temperature.");
    vout_update_a: assert property (
        adc_valid_in && adc_ch_out == CH_VOUT
        |=> mon_out.vout == $past(adc_data_in))
        else $error("Voltage result not refreshed.");
    retrieve_send_a: assert property (
        adc_valid_in && adc_ch_out == CH_TEMP && retrieve_en_in
        |=> mon_tx_valid_out && mon_tx_data_out.temp == $past(adc_data_in))
        else $error("Results not sent to power manager.");
    share_drive_a: assert property (
        !cs_oe_n_out |-> cs_out == 1'b0 && $past(share_act_reg))
        else $error("Share line driven outside a frame.");

    duty_seen_c: cover property (duty_valid_out && duty_out != 12'h000);
    tx_seen_c: cover property (mon_tx_valid_out);
    trim_up_c: cover property (trim_reg != 8'h00);
endmodule : pcc_core

// File: testbench/pcc_far_model.sv
// Far side model: ADC, a second paralleled unit and the ring buffer.
// Assumes the core's ports and types from pcc_pkg on a single clock.
`timescale 1ns/100ps
module pcc_far_model
    import pcc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic adc_start_in,
    input wire logic [1:0] adc_ch_in,
    input wire pcc_mon_s level_in,
    output logic adc_valid_out,
    output logic [7:0] adc_data_out,
    input wire logic share_sync_in,
    input wire logic [7:0] other_cur_in,
    input wire logic cs_line_in,
    output logic other_low_out,
    input wire logic tx_valid_in,
    input wire pcc_mon_s tx_data_in,
    output pcc_mon_s ring_last_out,
    output logic [7:0] ring_count_out,
    output logic [15:0] start_gap_out
);
    logic [2:0] conv_reg;
    logic [1:0] ch_reg;
    logic [15:0] gap_reg;
    logic [8:0] fr_reg;
    logic lead_reg;
    int bit_idx;

    // The converter answers four cycles after each start.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            adc_valid_out <= 1'b0;
            adc_data_out <= 8'h00;
            conv_reg <= 3'h0;
            ch_reg <= CH_VOUT;
        end else begin
            adc_valid_out <= (conv_reg == 3'h1);
            if (conv_reg == 3'h1) begin
                adc_data_out <= (ch_reg == CH_VOUT) ? level_in.vout :
                    (ch_reg == CH_IOUT) ? level_in.iout : level_in.temp;
            end else begin
                adc_data_out <= ~adc_data_out;
            end
            if (adc_start_in) begin
                conv_reg <= 3'h3;
                ch_reg <= adc_ch_in;
            end else if (conv_reg != 3'h0) begin
                conv_reg <= conv_reg - 3'h1;
            end
        end
    end

    // Spacing of conversion starts, in clock cycles.
    always_ff @(posedge clk_in) begin
        gap_reg <= adc_start_in ? 16'h0000 : gap_reg + 16'h0001;
        if (adc_start_in) begin
            start_gap_out <= gap_reg + 16'h0001;
        end
    end

    // Second unit drives its current bits, dropping out when it loses.
    assign bit_idx = 7 - (int'(fr_reg) - 1) / 50;
    assign other_low_out = (fr_reg != 9'h000) && lead_reg &&
        other_cur_in[bit_idx[2:0]];
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            fr_reg <= 9'h000;
            lead_reg <= 1'b0;
        end else if (fr_reg == 9'h000) begin
            fr_reg <= share_sync_in ? 9'h001 : 9'h000;
            lead_reg <= 1'b1;
        end else begin
            if ((fr_reg % 50) == 0 && !other_cur_in[bit_idx[2:0]] &&
                !cs_line_in) begin
                lead_reg <= 1'b0;
            end
            fr_reg <= (fr_reg == 9'h190) ? 9'h000 : fr_reg + 9'h001;
        end
    end

    // The manager stores each transferred result set.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ring_count_out <= 8'h00;
            ring_last_out <= '0;
        end else if (tx_valid_in) begin
            ring_count_out <= ring_count_out + 8'h01;
            ring_last_out <= tx_data_in;
        end
    end
endmodule : pcc_far_model

// File: testbench/test_pol_compensator_and_telemetry.sv
// Self-checking bench for the compensator and telemetry core.
// Assumes the far side model and a 50 MHz clock.
`timescale 1ns/100ps
module test_pol_compensator_and_telemetry
    import pcc_pkg::*;
;
    logic clk_in = 0, rst_in = 1, sw_tick_in = 0, coef_wr_in = 0;
    logic retrieve_en_in = 0, share_sync_in = 0;
    logic signed [7:0] err_in = 8'sh00;
    pcc_coef_wr_s coef_in = '0;
    pcc_mon_s level = '0, mon_out, tx_data, ring_last;
    logic [7:0] other_cur = 8'h00, adc_data, ring_count;
    logic [11:0] duty_out;
    logic [15:0] start_gap;
    logic [1:0] adc_ch;
    logic duty_valid, adc_start, adc_valid, tx_valid, cs_out, cs_oe_n;
    logic other_low, cs_line;
    int bad_count = 0, samples_checked = 0;

    assign cs_line = (cs_oe_n | cs_out) & ~other_low;

    pcc_core #(.SLOT_CYCLES(20)) i_dut (.clk_in(clk_in), .rst_in(rst_in),
        .sw_tick_in(sw_tick_in), .err_in(err_in), .coef_wr_in(coef_wr_in),
        .coef_in(coef_in), .adc_data_in(adc_data), .adc_valid_in(adc_valid),
        .retrieve_en_in(retrieve_en_in), .share_sync_in(share_sync_in),
        .cs_in(cs_line), .duty_out(duty_out), .duty_valid_out(duty_valid),
        .adc_start_out(adc_start), .adc_ch_out(adc_ch), .mon_out(mon_out),
        .mon_tx_valid_out(tx_valid), .mon_tx_data_out(tx_data),
        .cs_out(cs_out), .cs_oe_n_out(cs_oe_n));

    pcc_far_model i_far (.clk_in(clk_in), .rst_in(rst_in),
        .adc_start_in(adc_start), .adc_ch_in(adc_ch), .level_in(level),
        .adc_valid_out(adc_valid), .adc_data_out(adc_data),
        .share_sync_in(share_sync_in), .other_cur_in(other_cur),
        .cs_line_in(cs_line), .other_low_out(other_low),
        .tx_valid_in(tx_valid), .tx_data_in(tx_data),
        .ring_last_out(ring_last), .ring_count_out(ring_count),
        .start_gap_out(start_gap));

    initial begin
        forever #10 clk_in = ~clk_in;
    end

    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : chk

    task automatic wr_coef(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk_in);
        coef_wr_in = 1;
        coef_in = '{addr: a, data: d};
        @(negedge clk_in);
        coef_wr_in = 0;
    endtask : wr_coef

    // Numerators {c0,c1,c2,c3} as high and low bytes, denominators {b1,b2,b3}.
    task automatic set_coefs(input logic [63:0] num, input logic [23:0] den);
        for (int i = 0; i < 4; i++) begin
            wr_coef(4'(2 * i), num[63 - 16 * i -: 8]);
            wr_coef(4'(2 * i + 1), num[55 - 16 * i -: 8]);
        end
        for (int i = 0; i < 3; i++) begin
            wr_coef(COEF_DEN_BASE + 4'(i), den[23 - 8 * i -: 8]);
        end
        wr_coef(4'hb, 8'hff);
    endtask : set_coefs

    // One tick; optionally a second tick while busy, which must be ignored.
    task automatic tick(input logic signed [7:0] e, input logic extra,
                        input logic [11:0] exp);
        @(negedge clk_in);
        sw_tick_in = 1;
        err_in = e;
        @(negedge clk_in);
        sw_tick_in = 0;
        for (int i = 1; i <= 15; i++) begin
            if (i == 3) sw_tick_in = extra;
            if (i == 4) sw_tick_in = 0;
            @(negedge clk_in);
            // Step i looks between edges i and i+1 after the tick edge.
            if (i == 8) chk(duty_valid, 0);
            if (i == 9) chk(duty_valid, 1);
            if (i == 9) chk(duty_out, exp);
            if (i >= 10) chk(duty_valid, 0);
        end
    endtask : tick

    task automatic sc_taps;
        for (int k = 0; k < 4; k++) begin
            set_coefs(64'h1000 << (16 * (3 - k)), 24'h000000);
            for (int j = 0; j < 4; j++) begin
                tick(8'(j + 1), k == 2 && j == 1,
                     12'(j >= k ? j - k + 1 : 5 - k + j));
            end
        end
    endtask : sc_taps

    task automatic sc_poles;
        set_coefs({16'h0080, 48'h0}, 24'h000000);
        tick(100, 0, 12'h003);
        set_coefs({16'h1800, 48'h0}, 24'h000000);
        tick(10, 0, 12'h00f);
        set_coefs({16'h1000, 48'h0}, 24'h000000);
        tick(-100, 0, 12'h000);
        set_coefs({16'h7fff, 48'h0}, 24'hc00000);
        for (int j = 1; j <= 5; j++) begin
            tick(127, 0, 12'(j < 5 ? 1015 * j : 4095));
        end
        set_coefs({16'h1000, 48'h0}, 24'h00c000);
        tick(10, 0, 12'(4070));
        set_coefs({16'h1000, 48'h0}, 24'h0000c0);
        tick(10, 0, 12'(4070));
        set_coefs({16'h1000, 48'h0}, 24'h000000);
    endtask : sc_poles

    task automatic wait_tx;
        for (int i = 0; i < 200; i++) begin
            @(negedge clk_in);
            if (tx_valid === 1'b1) return;
        end
        bad_count++;
        print_verdict();
    endtask : wait_tx

    task automatic sc_mon;
        logic [23:0] tbl [3] = '{24'h398090, 24'h008073, 24'hffffff};
        logic [7:0] cnt;
        retrieve_en_in = 1;
        foreach (tbl[i]) begin
            level = '{vout: 8'h40, iout: tbl[i][15:8], temp: tbl[i][23:16]};
            repeat (3) wait_tx();
            chk(mon_out, {8'h40, tbl[i][7:0], tbl[i][23:16]});
            chk(tx_data, {8'h40, tbl[i][7:0], tbl[i][23:16]});
            @(negedge clk_in);
            chk(ring_last, mon_out);
            chk(start_gap, 20);
        end
        retrieve_en_in = 0;
        level = '{vout: 8'h55, iout: 8'h81, temp: 8'h19};
        cnt = ring_count;
        repeat (150) @(negedge clk_in);
        chk(mon_out, 24'h558119);
        chk(ring_count, cnt);
    endtask : sc_mon

    task automatic sc_share(input logic [7:0] other, input logic late_oe_n,
                            input logic [11:0] exp);
        other_cur = other;
        @(negedge clk_in);
        share_sync_in = 1;
        @(negedge clk_in);
        share_sync_in = 0;
        for (int i = 1; i <= 405; i++) begin
            @(negedge clk_in);
            if (i == 1) chk(cs_oe_n, 0);
            if (i == 360) chk(cs_oe_n, late_oe_n);
            if (i == 405) chk(cs_oe_n, 1);
        end
        tick(10, 0, exp);
    endtask : sc_share

    initial begin
        repeat (8) @(negedge clk_in);
        chk({duty_out, duty_valid, adc_start, cs_oe_n}, 15'h0001);
        chk(mon_out, 0);
        rst_in = 0;
        sc_taps();
        sc_poles();
        sc_mon();
        sc_share(8'hc0, 1, 12'h00b);
        sc_share(8'h00, 0, 12'h00a);
        print_verdict();
    end
endmodule : test_pol_compensator_and_telemetry
